// ==== rtl/akc_top.sv ====
// Register file, launch control and iterative block datapath of the key-order block
module akc_top (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [akc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [akc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [akc_pkg::DATA_W-1:0] reg_rdata,
	// Interrupt
	output logic irq
);
	import akc_pkg::*;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	akc_state_t state;
	akc_state_t next_state;
	logic [MODE_W-1:0] mode;
	logic [ENDIAN_W-1:0] endian;
	akc_word_t key [KEY_WORDS];
	akc_word_t text [TEXT_WORDS];
	logic [INT_W-1:0] int_stat;
	logic [INT_W-1:0] int_mask;
	logic [CNT_W-1:0] cnt;
	logic [RND_W-1:0] rnd;
	logic [BLOCK_W-1:0] blk;
	logic op_dec;
	akc_len_t op_len;
	logic [INT_W-1:0] int_set;

	akc_key_if kif ();

	// Word-aligned hit inside a bank of registers
	function automatic logic in_bank(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base, input int n);
		logic [ADDR_W-1:0] off;
		off = a - base;
		return (a >= base) && (off < ADDR_W'(n << WORD_SHIFT))
			&& (off[WORD_SHIFT-1:0] == '0);
	endfunction

	// Stand-in round key: both key halves folded with the round number
	function automatic logic [BLOCK_W-1:0] round_key(input logic [BLOCK_W-1:0] lo,
		input logic [BLOCK_W-1:0] hi, input logic [RND_W-1:0] r);
		return lo ^ hi ^ {BLOCK_BYTES{8'(r)}};
	endfunction

	//------------------------------------------------------------
	// Address decode
	//------------------------------------------------------------
	wire is_idle = (state == AKC_IDLE);
	wire hit_start = (reg_addr == OFF_START);
	wire hit_idle = (reg_addr == OFF_IDLE);
	wire hit_mode = (reg_addr == OFF_MODE);
	wire hit_endian = (reg_addr == OFF_ENDIAN);
	wire hit_stat = (reg_addr == OFF_INT_STAT);
	wire hit_mask = (reg_addr == OFF_INT_MASK);
	wire hit_key = in_bank(reg_addr, OFF_KEY0, KEY_WORDS);
	wire hit_text = in_bank(reg_addr, OFF_TEXT0, TEXT_WORDS);
	wire [2:0] key_idx = 3'((reg_addr - OFF_KEY0) >> WORD_SHIFT);
	wire [1:0] text_idx = 2'((reg_addr - OFF_TEXT0) >> WORD_SHIFT);

	// Launch and write qualification
	wire launch_wr = reg_write && hit_start && reg_wdata[START_BIT];
	wire go = launch_wr && is_idle;
	wire cfg_hit = hit_mode || hit_endian || hit_key || hit_text;
	wire busy_err = !is_idle && reg_write && (launch_wr || cfg_hit);
	wire cfg_ok = reg_write && is_idle;
	wire done_evt = !is_idle && (cnt == '0);

	//------------------------------------------------------------
	// Key assembly
	//------------------------------------------------------------
	assign kif.clk = clock;
	assign kif.rst = rst;
	assign kif.key_len = mode[MODE_LEN_LSB +: LEN_W];
	assign kif.word_natural = endian[END_WORD_BIT];
	assign kif.byte_swap = endian[END_BYTE_BIT];

	akc_key_order u_key_order (
		.kif(kif.assembler)
	);

	//------------------------------------------------------------
	// Block datapath
	//------------------------------------------------------------
	wire [BLOCK_W-1:0] key_lo = {kif.key_word[0], kif.key_word[1],
		kif.key_word[2], kif.key_word[3]};
	wire [BLOCK_W-1:0] key_hi = {kif.key_word[4], kif.key_word[5],
		kif.key_word[6], kif.key_word[7]};
	wire [BLOCK_W-1:0] rk_now = round_key(key_lo, key_hi, rnd);
	wire [BLOCK_W-1:0] rk_zero = round_key(key_lo, key_hi, '0);
	wire [BLOCK_W-1:0] text_blk = {text[0], text[1], text[2], text[3]};

	// Forward round and its exact inverse
	wire [BLOCK_W-1:0] enc_step = {blk[BLOCK_W-2:0], blk[BLOCK_W-1]} ^ rk_now;
	wire [BLOCK_W-1:0] dec_mix = blk ^ rk_now;
	wire [BLOCK_W-1:0] dec_step = {dec_mix[0], dec_mix[BLOCK_W-1:1]};
	wire [BLOCK_W-1:0] result = op_dec ? (blk ^ rk_zero) : blk;

	// Launch-time selection from the mode register
	wire mode_dec = mode[MODE_DEC_BIT];
	wire [LEN_W-1:0] mode_len = mode[MODE_LEN_LSB +: LEN_W];
	wire round_live = !is_idle && (op_dec ? (rnd != '0) : (rnd <= akc_rounds(op_len)));

	// Next values of the sequencer
	wire [CNT_W-1:0] next_cnt = go ? akc_latency(mode_len, mode_dec) - CNT_ONE :
		(is_idle || done_evt) ? cnt : cnt - CNT_ONE;
	wire [RND_W-1:0] next_rnd = go ? (mode_dec ? akc_rounds(mode_len) : RND_ONE) :
		round_live ? (op_dec ? rnd - RND_ONE : rnd + RND_ONE) : rnd;
	wire [BLOCK_W-1:0] next_blk = go ? (mode_dec ? text_blk : text_blk ^ rk_zero) :
		round_live ? (op_dec ? dec_step : enc_step) : blk;

	// Sequencer state
	always_comb
	begin
		next_state = state;
		case (state)
			AKC_IDLE: if (go) next_state = AKC_BUSY;
			AKC_BUSY: if (done_evt) next_state = AKC_IDLE;
			default: next_state = AKC_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= AKC_IDLE;
			cnt <= '0;
			rnd <= '0;
			blk <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			rnd <= next_rnd;
			blk <= next_blk;
		end
	end

	// Operation captured at launch
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			op_dec <= 1'b0;
			op_len <= KLEN_128;
		end
		else if (go)
		begin
			op_dec <= mode_dec;
			op_len <= mode_len;
		end
	end

	//------------------------------------------------------------
	// Register storage
	//------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < TEXT_WORDS; g++)
		begin : g_text
			wire wr_hit = cfg_ok && hit_text && (text_idx == 2'(g));
			// Block data: the only words the engine writes
			always_ff @(posedge clock)
			begin
				if (rst)
					text[g] <= TEXT_RST;
				else if (done_evt)
					text[g] <= result[BLOCK_W-1-DATA_W*g -: DATA_W];
				else if (wr_hit)
					text[g] <= reg_wdata;
			end
		end
		for (g = 0; g < KEY_WORDS; g++)
		begin : g_key
			wire wr_hit = cfg_ok && hit_key && (key_idx == 3'(g));
			assign kif.key_reg[g] = key[g];
			// Key words change only by software
			always_ff @(posedge clock)
			begin
				if (rst)
					key[g] <= KEY_RST;
				else if (wr_hit)
					key[g] <= reg_wdata;
			end
		end
	endgenerate

	// Configuration, written only while idle
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode <= MODE_RST;
			endian <= ENDIAN_RST;
		end
		else
		begin
			if (cfg_ok && hit_mode)
				mode <= reg_wdata[MODE_W-1:0];
			if (cfg_ok && hit_endian)
				endian <= reg_wdata[ENDIAN_W-1:0];
		end
	end

	//------------------------------------------------------------
	// Interrupts and read port
	//------------------------------------------------------------
	assign int_set[INT_DONE_BIT] = done_evt;
	assign int_set[INT_ERR_BIT] = busy_err;
	wire [INT_W-1:0] int_clr = (reg_write && hit_stat) ? reg_wdata[INT_W-1:0] : '0;
	wire [INT_W-1:0] next_int_stat = (int_stat & ~int_clr) | int_set; // Set wins
	wire [INT_W-1:0] next_int_mask = (reg_write && hit_mask) ?
		reg_wdata[INT_W-1:0] : int_mask;

	// Read selection; launch and unmapped locations read as zero
	wire [DATA_W-1:0] rd_mux =
		hit_idle ? DATA_W'(is_idle) :
		hit_mode ? DATA_W'(mode) :
		hit_endian ? DATA_W'(endian) :
		hit_key ? key[key_idx] :
		hit_text ? text[text_idx] :
		hit_stat ? DATA_W'(int_stat) :
		hit_mask ? DATA_W'(int_mask) : '0;
	wire [DATA_W-1:0] next_rdata = reg_read ? rd_mux : '0;

	// Status, mask and output flops
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			int_stat <= INT_RST;
			int_mask <= INT_RST;
			irq <= 1'b0;
			reg_rdata <= '0;
		end
		else
		begin
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			irq <= |(next_int_stat & next_int_mask);
			reg_rdata <= next_rdata;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// Cycles since launch, for latency checks
	logic [CNT_W-1:0] lat_cnt;
	always_ff @(posedge clock)
	begin
		if (rst)
			lat_cnt <= '0;
		else if (go)
			lat_cnt <= CNT_ONE;
		else if (!is_idle)
			lat_cnt <= lat_cnt + CNT_ONE;
	end

	enc_latency_a: assert property (
		done_evt && !op_dec |-> lat_cnt >= ENC_LAT_128 && lat_cnt <= ENC_LAT_256
		&& lat_cnt == akc_latency(op_len, 1'b0))
		else $error("encrypt latency out of range");
	dec_latency_a: assert property (
		done_evt && op_dec |-> lat_cnt == DEC_LAT_SHORT || lat_cnt == DEC_LAT_LONG)
		else $error("decrypt latency out of range");
	busy_window_a: assert property (
		go |=> !is_idle [*8] ##[4:15] is_idle)
		else $error("done status not low for the operation");
	done_read_a: assert property (
		done_evt ##1 (reg_read && hit_idle) |=> reg_rdata[0])
		else $error("done status not reading one");
	result_load_a: assert property (
		done_evt |=> text[0] == $past(result[BLOCK_W-1 -: DATA_W]) && is_idle)
		else $error("result not in block data");
	keep_cfg_a: assert property (
		done_evt |=> mode == $past(mode) && endian == $past(endian)
		&& key[0] == $past(key[0]) && key[7] == $past(key[7]))
		else $error("completion changed configuration");
	launch_wo_a: assert property (
		reg_read && hit_start |=> reg_rdata == '0)
		else $error("launch location not reading zero");
	text_reset_a: assert property (
		$past(rst) |-> text[0] == TEXT_RST && text[3] == TEXT_RST)
		else $error("block data not zero after reset");
	op_select_a: assert property (
		go |=> op_dec == $past(mode_dec))
		else $error("operation selection not taken");

	enc_done_c: cover property (done_evt && !op_dec && op_len == KLEN_256);
	dec_done_c: cover property (done_evt && op_dec);
	busy_err_c: cover property (busy_err);
	irq_c: cover property (done_evt ##1 irq);
endmodule

// ==== rtl/akc_pkg.sv ====
// Constants, types and helper functions of the AES key-order and launch control block
//------------------------------------------------------------
//------------------------------------------------------------
package akc_pkg;
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int KEY_WORDS = 8;
	localparam int TEXT_WORDS = 4;
	localparam int BLOCK_W = DATA_W * TEXT_WORDS;
	localparam int BLOCK_BYTES = BLOCK_W / 8;
	localparam int WORD_SHIFT = 2;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_START = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_IDLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_KEY0 = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TEXT0 = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_ENDIAN = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h48;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h4C;
	// Field layouts
	localparam int MODE_W = 3;
	localparam int MODE_LEN_LSB = 0;
	localparam int LEN_W = 2;
	localparam int MODE_DEC_BIT = 2;
	localparam int ENDIAN_W = 6;
	localparam int END_BYTE_BIT = 0;
	localparam int END_WORD_BIT = 1;
	localparam int START_BIT = 0;
	localparam int INT_W = 2;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_ERR_BIT = 1;
	// Reset values
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic [ENDIAN_W-1:0] ENDIAN_RST = 6'h00;
	localparam logic [DATA_W-1:0] TEXT_RST = 32'h00000000;
	localparam logic [DATA_W-1:0] KEY_RST = 32'h00000000;
	localparam logic [INT_W-1:0] INT_RST = 2'h0;
	// Key length codes in the mode register
	localparam logic [LEN_W-1:0] KLEN_128 = 2'h0;
	localparam logic [LEN_W-1:0] KLEN_192 = 2'h1;
	localparam logic [LEN_W-1:0] KLEN_256 = 2'h2;
	localparam logic [3:0] NK_128 = 4'h4;
	localparam logic [3:0] NK_192 = 4'h6;
	localparam logic [3:0] NK_256 = 4'h8;
	// Round counts and latencies in clock cycles
	localparam int RND_W = 4;
	localparam int CNT_W = 5;
	localparam logic [RND_W-1:0] RND_ONE = 4'h1;
	localparam logic [RND_W-1:0] ROUNDS_128 = 4'hA;
	localparam logic [RND_W-1:0] ROUNDS_192 = 4'hC;
	localparam logic [RND_W-1:0] ROUNDS_256 = 4'hE;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] ENC_LAT_128 = 5'h0B;
	localparam logic [CNT_W-1:0] ENC_LAT_192 = 5'h0D;
	localparam logic [CNT_W-1:0] ENC_LAT_256 = 5'h0F;
	localparam logic [CNT_W-1:0] DEC_LAT_SHORT = 5'h15;
	localparam logic [CNT_W-1:0] DEC_LAT_LONG = 5'h16;

	typedef logic [DATA_W-1:0] akc_word_t;
	typedef logic [LEN_W-1:0] akc_len_t;
	typedef enum {AKC_IDLE, AKC_BUSY} akc_state_t;

	// Number of key words in use; unused code behaves as 128-bit
	function automatic logic [3:0] akc_nk(input akc_len_t len);
		case (len)
			KLEN_192: return NK_192;
			KLEN_256: return NK_256;
			default: return NK_128;
		endcase
	endfunction

	// Rounds per key length
	function automatic logic [RND_W-1:0] akc_rounds(input akc_len_t len);
		case (len)
			KLEN_192: return ROUNDS_192;
			KLEN_256: return ROUNDS_256;
			default: return ROUNDS_128;
		endcase
	endfunction

	// Cycles from launch to completion
	function automatic logic [CNT_W-1:0] akc_latency(input akc_len_t len, input logic dec);
		case (len)
			KLEN_192: return dec ? DEC_LAT_SHORT : ENC_LAT_192;
			KLEN_256: return dec ? DEC_LAT_LONG : ENC_LAT_256;
			default: return dec ? DEC_LAT_SHORT : ENC_LAT_128;
		endcase
	endfunction

	// Byte reversal within one word
	function automatic akc_word_t akc_bswap(input akc_word_t w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction
endpackage

// ==== rtl/akc_key_if.sv ====
// Interface carrying key registers and assembled key words between control and assembler
interface akc_key_if;
	import akc_pkg::*;
	logic clk;
	logic rst;
	akc_word_t key_reg [KEY_WORDS];
	akc_len_t key_len;
	logic word_natural;
	logic byte_swap;
	akc_word_t key_word [KEY_WORDS];
	modport ctrl (output clk, rst, key_reg, key_len, word_natural, byte_swap, input key_word);
	modport assembler (input clk, rst, key_reg, key_len, word_natural, byte_swap, output key_word);
endinterface

// ==== rtl/akc_key_order.sv ====
// Key word assembler: word order and byte order selection over the key registers
module akc_key_order (
	// Key registers in, key words out
	akc_key_if.assembler kif
);
	import akc_pkg::*;

	//------------------------------------------------------------
	// Word and byte selection
	//------------------------------------------------------------
	wire [3:0] nk = akc_nk(kif.key_len);

	genvar i;
	generate
		for (i = 0; i < KEY_WORDS; i++)
		begin : g_word
			// Reversed order counts down from the last word in use
			wire [3:0] rev_idx = nk - 4'(i) - 4'h1;
			wire [2:0] src = kif.word_natural ? 3'(i) : rev_idx[2:0];
			wire in_use = 4'(i) < nk;
			wire [DATA_W-1:0] picked = kif.key_reg[src];
			// Words beyond the key length read as zero
			assign kif.key_word[i] = !in_use ? '0 :
				kif.byte_swap ? akc_bswap(picked) : picked;
		end
	endgenerate

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	word_rev_a: assert property (
		@(posedge kif.clk) disable iff (kif.rst)
		!kif.word_natural && !kif.byte_swap && kif.key_len == KLEN_128
		|-> kif.key_word[0] == kif.key_reg[3] && kif.key_word[3] == kif.key_reg[0])
		else $error("reversed word order wrong");
	word_nat_a: assert property (
		@(posedge kif.clk) disable iff (kif.rst)
		kif.word_natural && !kif.byte_swap
		|-> kif.key_word[0] == kif.key_reg[0] && kif.key_word[3] == kif.key_reg[3])
		else $error("natural word order wrong");
	byte_rev_a: assert property (
		@(posedge kif.clk) disable iff (kif.rst)
		kif.word_natural && kif.byte_swap
		|-> kif.key_word[1][31:24] == kif.key_reg[1][7:0]
		&& kif.key_word[1][7:0] == kif.key_reg[1][31:24])
		else $error("byte reversal wrong");
	key_192_a: assert property (
		@(posedge kif.clk) disable iff (kif.rst)
		!kif.word_natural && !kif.byte_swap && kif.key_len == KLEN_192
		|-> kif.key_word[0] == kif.key_reg[5] && kif.key_word[5] == kif.key_reg[0]
		&& kif.key_word[6] == '0)
		else $error("192-bit key assembly wrong");
	key_256_a: assert property (
		@(posedge kif.clk) disable iff (kif.rst)
		!kif.word_natural && !kif.byte_swap && kif.key_len == KLEN_256
		|-> kif.key_word[0] == kif.key_reg[7] && kif.key_word[7] == kif.key_reg[0])
		else $error("256-bit key assembly wrong");
endmodule

// ==== verif/akc_top_tb.sv ====
// Self-checking testbench of the AES key-order and launch control block
module akc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import akc_pkg::*;
	logic clock;
	logic rst;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [DATA_W-1:0] reg_rdata;
	logic irq;
	int mismatches;
	int num_checks;
	int cycles = 0;
	logic [BLOCK_W-1:0] pt;
	logic [BLOCK_W-1:0] ct0;

	akc_top u_dut (
		.clock(clock),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.irq(irq)
	);

	// Clock at 20 MHz
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic give_verdict;
		$display("Checks made %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [BLOCK_W-1:0] seen, input logic [BLOCK_W-1:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'h0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'h0;
		@(negedge clock);
		d = reg_rdata;
	endtask

	function automatic logic [DATA_W-1:0] key_val(input int i);
		return 32'hA0B1C2D3 + 32'(i) * 32'h01020304;
	endfunction

	function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	// Variant 0 natural, 1 reversed words, 2 swapped bytes, 3 altered key
	task automatic set_keys(input int nk, input int v);
		logic [DATA_W-1:0] k;
		for (int i = 0; i < KEY_WORDS; i++)
		begin
			k = (i < nk) ? key_val((v == 1) ? nk - 1 - i : i) : 32'hC0DE0000 + 32'(16 * v + i);
			if (v == 2 && i < nk)
				k = swap_bytes(k);
			if (v == 3 && i == 0)
				k = ~k;
			wr(OFF_KEY0 + 8'(4 * i), k);
		end
		wr(OFF_ENDIAN, (v == 1) ? 32'h0 : (v == 2) ? 32'h3 : 32'h2);
	endtask

	task automatic load_text(input logic [BLOCK_W-1:0] txt);
		for (int i = 0; i < TEXT_WORDS; i++)
			wr(OFF_TEXT0 + 8'(4 * i), txt[BLOCK_W-1-32*i -: 32]);
	endtask

	task automatic read_text(output logic [BLOCK_W-1:0] res);
		logic [DATA_W-1:0] d;
		for (int i = 0; i < TEXT_WORDS; i++)
		begin
			rd(OFF_TEXT0 + 8'(4 * i), d);
			res[BLOCK_W-1-32*i -: 32] = d;
		end
	endtask

	// Load, launch, time the idle flag with back-to-back reads, fetch result
	task automatic run_op(input logic [2:0] m, input logic [BLOCK_W-1:0] txt,
		output logic [BLOCK_W-1:0] res);
		int n;
		int lat;
		// Expected cycles from launch to completion; length code 3 runs as 128-bit
		lat = m[2] ? ((m[1:0] == 2'h2) ? 22 : 21) :
			(m[1:0] == 2'h3) ? 11 : 11 + 2 * m[1:0];
		load_text(txt);
		wr(OFF_MODE, {29'h0, m});
		wr(OFF_START, 32'h1);
		reg_read <= 1'h1;
		reg_addr <= OFF_IDLE;
		n = 0;
		do
		begin
			n++;
			@(posedge clock);
			@(negedge clock);
			if (reg_rdata !== 32'h1)
				check(reg_rdata, 0);
		end while (reg_rdata !== 32'h1 && n < 40);
		@(posedge clock);
		reg_read <= 1'h0;
		// Each idle read reports the state of the cycle before it
		check(n - 1, lat);
		read_text(res);
	endtask

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic reset_vals;
		logic [ADDR_W-1:0] a [10] = '{8'h30, 8'h34, 8'h38, 8'h3C, 8'h04, 8'h08, 8'h40,
			8'h10, 8'h00, 8'h80};
		logic [DATA_W-1:0] d;
		wr(OFF_IDLE, 32'h0);
		for (int i = 0; i < 10; i++)
		begin
			rd(a[i], d);
			check(d, (i == 4) ? 1 : 0);
		end
		check(irq, 0);
	endtask

	// Same key words through different register layouts give the same result
	task automatic key_order;
		logic [BLOCK_W-1:0] r [4];
		logic [BLOCK_W-1:0] back;
		logic [DATA_W-1:0] d;
		for (int len = 0; len < 3; len++)
		begin
			for (int v = 3; v >= 0; v--)
			begin
				set_keys(4 + 2 * len, v);
				run_op(3'(len), pt, r[v]);
			end
			check(r[1], r[0]);
			check(r[2], r[0]);
			check(r[3] !== r[0], 1);
			check(r[0] !== pt, 1);
			run_op(3'(4 + len), r[0], back);
			check(back, pt);
			rd(OFF_ENDIAN, d);
			check(d, 2);
			rd(OFF_KEY0, d);
			check(d, key_val(0));
			if (len == 0)
				ct0 = r[0];
		end
	endtask

	// Writes while busy, then the interrupt status and mask
	task automatic busy_irq;
		logic [DATA_W-1:0] d;
		logic [BLOCK_W-1:0] res;
		int n;
		set_keys(4, 0);
		load_text(pt);
		wr(OFF_MODE, 32'h0);
		wr(OFF_START, 32'h1);
		wr(OFF_TEXT0, 32'h0BAD0BAD);
		wr(OFF_START, 32'h1);
		n = 0;
		do
		begin
			rd(OFF_IDLE, d);
			n++;
		end while (d !== 32'h1 && n < 40);
		check(d, 1);
		read_text(res);
		check(res, ct0);
		rd(OFF_INT_STAT, d);
		check(d, 3);
		check(irq, 0);
		wr(OFF_INT_MASK, 32'h1);
		rd(OFF_INT_MASK, d);
		check(d, 1);
		check(irq, 1);
		wr(OFF_INT_STAT, 32'h1);
		rd(OFF_INT_STAT, d);
		check(d, 2);
		check(irq, 0);
		wr(OFF_INT_MASK, 32'h3);
		rd(OFF_INT_MASK, d);
		check(irq, 1);
		wr(OFF_INT_STAT, 32'h2);
		rd(OFF_INT_STAT, d);
		check(d, 0);
		check(irq, 0);
		// Unused length code behaves as a 128-bit key
		run_op(3'h3, pt, res);
		check(res, ct0);
	endtask

	//------------------------------------------------------------
	// Main sequence and hang guard
	//------------------------------------------------------------
	initial
	begin
		rst = 1'h1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'h0;
		reg_read = 1'h0;
		mismatches = 0;
		num_checks = 0;
		pt = 128'h00112233445566778899AABBCCDDEEFF;
		repeat (3) @(posedge clock);
		rst <= 1'h0;
		reset_vals;
		key_order;
		busy_irq;
		give_verdict;
	end

	// Ceiling well above the roughly one thousand cycles the scenarios need
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			give_verdict;
		end
	end
endmodule
